// >>> hw/headphone_dc_servo_registers.sv
/*
  register bank of the headphone dc offset servo: configuration,
  triggers, completion status, offset readback and the left headphone
  stage enables, plus the periodic update timer.
  assumes the serial control interface presents decoded single-cycle
  register writes and reads on this clock, and that the analogue
  servo answers each correction start with one corr_done pulse.
*/
`timescale 1ns/1ps

module headphone_dc_servo_registers
  import servo_regs_pkg::*;
#(
  parameter int unit_cycles = servo_regs_pkg::UNIT_CYCLES
)(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [15:0]      reg_wdata,
  input  wire logic             reg_write,
  input  wire logic             reg_read,
  output      logic [15:0]      reg_rdata,
  output      logic [1:0]       corr_start,
  output      logic [1:0]       corr_use_value,
  output      logic [1:0][7:0]  corr_value,
  input  wire logic [1:0]       corr_done,
  input  wire logic [1:0][7:0]  corr_result,
  output      logic             left_short_removal,
  output      logic             left_output_stage_on,
  output      logic             left_intermediate_stage_on
);

  typedef struct packed {
    logic [6:0]  series_update_count;
    logic [3:0]  periodic_interval_code;
    logic [7:0]  left_offset_write_value;
    logic [7:0]  right_offset_write_value;
    logic [1:0]  servo_on;
    logic        short_rm;
    logic        outp;
    logic        dly;
    logic [23:0] tick_cnt;
    logic [15:0] ticks;
    logic        periodic;
    logic [1:0]  trig_series;
    logic [1:0]  trig_startup;
    logic [1:0]  trig_write;
    logic [15:0] rdata;
  } bank_t;

  bank_t st;
  bank_t next_st;

  servo_chan_if chan[2] ();

  logic [1:0] busy_series;
  logic [1:0] busy_startup;
  logic [1:0] busy_write;
  logic [1:0] startup_done_flags;
  logic [1:0] offset_write_done_flags;
  logic [1:0] correction_done_flags;
  logic [1:0][7:0] chan_readback;
  logic [15:0] read_value;
  logic [15:0] interval_ticks;
  logic wr_ctrl;
  logic wr_cfg;
  logic wr_values;
  logic wr_stage;

  ////////////////////////////////////////////////////////////////////////
  // per-channel engines
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_chan
      assign chan[g].trig_series  = st.trig_series[g];
      assign chan[g].trig_startup = st.trig_startup[g];
      assign chan[g].trig_write   = st.trig_write[g];
      assign chan[g].periodic     = st.periodic;
      assign chan[g].enable       = st.servo_on[g];
      assign chan[g].count        = st.series_update_count;
      assign chan[g].write_value  = (g == LEFT)
                                    ? st.left_offset_write_value
                                    : st.right_offset_write_value;
      assign busy_series[g]             = chan[g].busy_series;
      assign busy_startup[g]            = chan[g].busy_startup;
      assign busy_write[g]              = chan[g].busy_write;
      assign startup_done_flags[g]      = chan[g].done_startup;
      assign offset_write_done_flags[g] = chan[g].done_write;
      assign chan_readback[g]           = chan[g].readback;
      assign corr_value[g]              = chan[g].write_value;

      servo_engine u_engine (
        .clk            (clk),
        .resetn         (resetn),
        .ch             (chan[g]),
        .corr_start     (corr_start[g]),
        .corr_use_value (corr_use_value[g]),
        .corr_done      (corr_done[g]),
        .corr_result    (corr_result[g])
      );
    end
  endgenerate

  // start-up or offset-write mode finishing counts as complete; series mode sets no flag
  assign correction_done_flags = startup_done_flags
                               | offset_write_done_flags;

  ////////////////////////////////////////////////////////////////////////
  // register decode and read mux
  assign wr_ctrl   = reg_write && (reg_addr == ADDR_SERVO_CTRL);
  assign wr_cfg    = reg_write && (reg_addr == ADDR_SERIES_TIMER);
  assign wr_values = reg_write && (reg_addr == ADDR_WRITE_VALUES);
  assign wr_stage  = reg_write && (reg_addr == ADDR_HP_STAGE);

  assign interval_ticks = 16'h0001 << st.periodic_interval_code;

  always_comb begin
    read_value = 16'h0000;
    unique case (reg_addr)
      ADDR_SERVO_CTRL: begin
        read_value[SERIES_TRIG_LSB +: 2]  = busy_series;
        read_value[STARTUP_TRIG_LSB +: 2] = busy_startup;
        read_value[WRITE_TRIG_LSB +: 2]   = busy_write;
        read_value[SERVO_ON_LSB +: 2]     = st.servo_on;
      end
      ADDR_SERIES_TIMER: begin
        read_value[SERIES_MSB:SERIES_LSB]     = st.series_update_count;
        read_value[INTERVAL_MSB:INTERVAL_LSB] = st.periodic_interval_code;
      end
      ADDR_WRITE_VALUES: begin
        read_value[LEFT_WV_LSB +: 8]  = st.left_offset_write_value;
        read_value[RIGHT_WV_LSB +: 8] = st.right_offset_write_value;
      end
      ADDR_COMPLETION: begin
        read_value[CORR_DONE_LSB +: 2]    = correction_done_flags;
        read_value[WRITE_DONE_LSB +: 2]   = offset_write_done_flags;
        read_value[STARTUP_DONE_LSB +: 2] = startup_done_flags;
      end
      ADDR_LEFT_RB:  read_value[7:0] = chan_readback[LEFT];
      ADDR_RIGHT_RB: read_value[7:0] = chan_readback[RIGHT];
      ADDR_HP_STAGE: begin
        read_value[SHORT_RM_BIT] = st.short_rm;
        read_value[OUTP_BIT]     = st.outp;
        read_value[DLY_BIT]      = st.dly;
      end
      default: read_value = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    // triggers are one-cycle pulses
    next_st.trig_series  = 2'b00;
    next_st.trig_startup = 2'b00;
    next_st.trig_write   = 2'b00;
    next_st.periodic     = 1'b0;
    if (wr_ctrl) begin
      next_st.trig_series  = reg_wdata[SERIES_TRIG_LSB +: 2];
      next_st.trig_startup = reg_wdata[STARTUP_TRIG_LSB +: 2];
      next_st.trig_write   = reg_wdata[WRITE_TRIG_LSB +: 2];
      next_st.servo_on     = reg_wdata[SERVO_ON_LSB +: 2];
    end
    if (wr_cfg) begin
      next_st.series_update_count =
        reg_wdata[SERIES_MSB:SERIES_LSB];
      next_st.periodic_interval_code =
        reg_wdata[INTERVAL_MSB:INTERVAL_LSB];
    end
    if (wr_values) begin
      next_st.left_offset_write_value  = reg_wdata[LEFT_WV_LSB +: 8];
      next_st.right_offset_write_value =
        reg_wdata[RIGHT_WV_LSB +: 8];
    end
    if (wr_stage) begin
      next_st.short_rm = reg_wdata[SHORT_RM_BIT];
      next_st.outp     = reg_wdata[OUTP_BIT];
      next_st.dly      = reg_wdata[DLY_BIT];
    end
    if (reg_read) begin
      next_st.rdata = read_value;
    end
    // periodic timer, counts units of 0.256 s
    if (st.periodic_interval_code == 4'h0 || wr_cfg) begin
      next_st.tick_cnt = 24'h000000;
      next_st.ticks    = 16'h0000;
    end else if (st.tick_cnt == 24'(unit_cycles - 1)) begin
      next_st.tick_cnt = 24'h000000;
      if (st.ticks == interval_ticks - 16'h0001) begin
        next_st.ticks    = 16'h0000;
        next_st.periodic = 1'b1;
      end else begin
        next_st.ticks = st.ticks + 16'h0001;
      end
    end else begin
      next_st.tick_cnt = st.tick_cnt + 24'h000001;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '{SERIES_RESET, INTERVAL_RESET, WV_RESET, WV_RESET, 2'b00,
              1'b0, 1'b0, 1'b0, 24'h000000, 16'h0000, 1'b0, 2'b00,
              2'b00, 2'b00, 16'h0000};
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata                  = st.rdata;
  assign left_short_removal         = st.short_rm;
  assign left_output_stage_on       = st.outp;
  assign left_intermediate_stage_on = st.dly;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_series_cfg;
    wr_cfg |=> st.series_update_count == $past(reg_wdata[11:5]);
  endproperty
  a_series_cfg: assert property (p_series_cfg)
    else $error("series count not stored");

  property p_timer_off;
    st.periodic_interval_code == 4'h0 |-> ##1 !st.periodic;
  endproperty
  a_timer_off: assert property (p_timer_off)
    else $error("periodic update with timer off");

  property p_values;
    wr_values |=> st.left_offset_write_value == $past(reg_wdata[15:8])
              && st.right_offset_write_value == $past(reg_wdata[7:0]);
  endproperty
  a_values: assert property (p_values)
    else $error("offset write values not stored");

  property p_corr_flags;
    $rose(correction_done_flags[LEFT])
      |-> $past(corr_done[LEFT]
                && (busy_write[LEFT] || busy_startup[LEFT]));
  endproperty
  a_corr_flags: assert property (p_corr_flags)
    else $error("combined completion flag wrong");

  property p_status_read;
    reg_read && reg_addr == ADDR_COMPLETION
      |=> reg_rdata[5:4] == $past(offset_write_done_flags)
       && reg_rdata[1:0] == $past(startup_done_flags);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("completion status readback wrong");

  property p_left_rb;
    reg_read && reg_addr == ADDR_LEFT_RB
      |=> reg_rdata == {8'h00, $past(chan_readback[LEFT])};
  endproperty
  a_left_rb: assert property (p_left_rb)
    else $error("left offset readback wrong");

  property p_right_rb;
    reg_read && reg_addr == ADDR_RIGHT_RB
      |=> reg_rdata == {8'h00, $past(chan_readback[RIGHT])};
  endproperty
  a_right_rb: assert property (p_right_rb)
    else $error("right offset readback wrong");

  property p_stage;
    wr_stage |=> left_short_removal == $past(reg_wdata[7])
              && left_output_stage_on == $past(reg_wdata[6])
              && left_intermediate_stage_on == $past(reg_wdata[5]);
  endproperty
  a_stage: assert property (p_stage)
    else $error("headphone stage bits not applied");

  property p_write_trig;
    wr_ctrl && reg_wdata[3] && reg_wdata[1] && !busy_series[LEFT]
      && !busy_startup[LEFT] && !busy_write[LEFT] && st.servo_on[LEFT]
      |=> ##1 busy_write[LEFT] && corr_use_value[LEFT];
  endproperty
  a_write_trig: assert property (p_write_trig)
    else $error("left offset write did not start");

  c_periodic: cover property (st.periodic);
  c_both_done: cover property (correction_done_flags == 2'b11);

endmodule // headphone_dc_servo_registers

// >>> hw/servo_regs_pkg.sv
/*
  constants, register map and types shared by the headphone servo
  register bank and its per-channel correction engine.
  assumes a single 50 mhz clock and 16-bit register data.
*/
package servo_regs_pkg;

  localparam int          CLK_HZ           = 50_000_000;
  localparam real         UNIT_TIME_S      = 0.256;
  localparam int          UNIT_CYCLES      = int'(UNIT_TIME_S * CLK_HZ);

  localparam logic [7:0]  ADDR_SERVO_CTRL  = 8'h54;
  localparam logic [7:0]  ADDR_SERIES_TIMER = 8'h55;
  localparam logic [7:0]  ADDR_WRITE_VALUES = 8'h57;
  localparam logic [7:0]  ADDR_COMPLETION  = 8'h58;
  localparam logic [7:0]  ADDR_LEFT_RB     = 8'h59;
  localparam logic [7:0]  ADDR_RIGHT_RB    = 8'h5a;
  localparam logic [7:0]  ADDR_HP_STAGE    = 8'h60;

  // control register fields
  localparam int          SERIES_TRIG_LSB  = 8;
  localparam int          STARTUP_TRIG_LSB = 4;
  localparam int          WRITE_TRIG_LSB   = 2;
  localparam int          SERVO_ON_LSB     = 0;
  // series and timer fields
  localparam int          SERIES_MSB       = 11;
  localparam int          SERIES_LSB       = 5;
  localparam int          INTERVAL_MSB     = 3;
  localparam int          INTERVAL_LSB     = 0;
  localparam logic [6:0]  SERIES_RESET     = 7'h2a;
  localparam logic [3:0]  INTERVAL_RESET   = 4'ha;
  // write value fields
  localparam int          LEFT_WV_LSB      = 8;
  localparam int          RIGHT_WV_LSB     = 0;
  localparam logic [7:0]  WV_RESET         = 8'h00;
  // completion status fields
  localparam int          CORR_DONE_LSB    = 8;
  localparam int          WRITE_DONE_LSB   = 4;
  localparam int          STARTUP_DONE_LSB = 0;
  // headphone stage bits
  localparam int          SHORT_RM_BIT     = 7;
  localparam int          OUTP_BIT         = 6;
  localparam int          DLY_BIT          = 5;

  localparam int          LEFT             = 1;
  localparam int          RIGHT            = 0;

  typedef enum logic [1:0] {MODE_SERIES, MODE_STARTUP, MODE_WRITE} mode_t;

endpackage

// >>> hw/servo_chan_if.sv
/*
  per-channel link between the register bank and one correction engine.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface servo_chan_if;
  logic       trig_series;
  logic       trig_startup;
  logic       trig_write;
  logic       periodic;
  logic       enable;
  logic [6:0] count;
  logic [7:0] write_value;
  logic       busy_series;
  logic       busy_startup;
  logic       busy_write;
  logic       done_startup;
  logic       done_write;
  logic [7:0] readback;

  modport ctrl (
    output trig_series, trig_startup, trig_write, periodic, enable,
           count, write_value,
    input  busy_series, busy_startup, busy_write, done_startup,
           done_write, readback
  );
  modport engine (
    input  trig_series, trig_startup, trig_write, periodic, enable,
           count, write_value,
    output busy_series, busy_startup, busy_write, done_startup,
           done_write, readback
  );
endinterface

// >>> hw/servo_engine.sv
/*
  one channel's correction sequencer: runs series, start-up and
  offset-write corrections against the analogue servo and keeps the
  channel's completion flags and readback value.
  assumes the analogue side answers each start with one done pulse.
*/
`timescale 1ns/1ps
module servo_engine
  import servo_regs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  servo_chan_if.engine    ch,
  output      logic       corr_start,
  output      logic       corr_use_value,
  input  wire logic       corr_done,
  input  wire logic [7:0] corr_result
);

  typedef enum logic {IDLE, RUN} state_t;

  typedef struct packed {
    state_t     state;
    mode_t      mode;
    logic [6:0] remaining;
    logic       start;
    logic       done_startup;
    logic       done_write;
    logic [7:0] readback;
  } eng_t;

  eng_t st;
  eng_t next_st;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.start = 1'b0;
    unique case (st.state)
      IDLE: begin
        if (ch.enable) begin
          if (ch.trig_write) begin
            next_st.mode = MODE_WRITE;
            next_st.done_write = 1'b0;
            next_st.state = RUN;
            next_st.start = 1'b1;
          end else if (ch.trig_startup) begin
            next_st.mode = MODE_STARTUP;
            next_st.done_startup = 1'b0;
            next_st.state = RUN;
            next_st.start = 1'b1;
          end else if (ch.trig_series) begin
            next_st.mode = MODE_SERIES;
            next_st.remaining = ch.count;
            next_st.state = RUN;
            next_st.start = 1'b1;
          end else if (ch.periodic) begin
            next_st.mode = MODE_SERIES;
            next_st.remaining = 7'h00;
            next_st.state = RUN;
            next_st.start = 1'b1;
          end
        end
      end
      RUN: begin
        if (!ch.enable) begin
          next_st.state = IDLE;
        end else if (corr_done) begin
          next_st.readback = (st.mode == MODE_WRITE) ? ch.write_value
                                                     : corr_result;
          if (st.mode == MODE_SERIES && st.remaining != 7'h00) begin
            next_st.remaining = st.remaining - 7'h01;
            next_st.start = 1'b1;
          end else begin
            next_st.state = IDLE;
            if (st.mode == MODE_WRITE) next_st.done_write = 1'b1;
            if (st.mode == MODE_STARTUP) next_st.done_startup = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '{IDLE, MODE_SERIES, 7'h00, 1'b0, 1'b0, 1'b0, 8'h00};
    end else begin
      st <= next_st;
    end
  end

  assign corr_start      = st.start;
  assign corr_use_value  = (st.state == RUN) && (st.mode == MODE_WRITE);
  assign ch.busy_series  = (st.state == RUN) && (st.mode == MODE_SERIES);
  assign ch.busy_startup = (st.state == RUN) && (st.mode == MODE_STARTUP);
  assign ch.busy_write   = corr_use_value;
  assign ch.done_startup = st.done_startup;
  assign ch.done_write   = st.done_write;
  assign ch.readback     = st.readback;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_series_start;
    st.state == IDLE && ch.enable && ch.trig_series && !ch.trig_write
      && !ch.trig_startup |=> ch.busy_series && corr_start;
  endproperty
  a_series_start: assert property (p_series_start)
    else $error("series trigger did not start a series");

  property p_disabled_idle;
    !ch.enable |=> st.state == IDLE ##0 !corr_start;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("correction active on disabled channel");

  property p_write_flag;
    st.state == IDLE && ch.enable && ch.trig_write
      |=> !ch.done_write && ch.busy_write;
  endproperty
  a_write_flag: assert property (p_write_flag)
    else $error("write flag not cleared on trigger");

  property p_write_finish;
    ch.busy_write && ch.enable && corr_done
      |=> ch.done_write && ch.readback == $past(ch.write_value);
  endproperty
  a_write_finish: assert property (p_write_finish)
    else $error("offset write did not complete");

  property p_startup_finish;
    ch.busy_startup && ch.enable && corr_done
      |=> ch.done_startup && !ch.busy_startup;
  endproperty
  a_startup_finish: assert property (p_startup_finish)
    else $error("start-up correction did not complete");

  c_series_repeat: cover property (ch.busy_series && corr_done
                                   ##1 corr_start);
  c_write_done: cover property ($rose(ch.done_write));
  c_startup_done: cover property ($rose(ch.done_startup));

endmodule // servo_engine

// >>> verification/servo_regs_tb.sv
/*
  bench for the headphone servo register bank: drives register strobes
  and answers correction starts in place of the analogue servo.
  assumes one-cycle read latency and a shortened timer unit.
*/
`timescale 1ns/1ps
module headphone_dc_servo_registers_tb_top;
  import servo_regs_pkg::*;
  typedef struct {logic [7:0] a; logic [15:0] e;} note_t;
  logic            clk = 0;
  logic            resetn = 0;
  logic [7:0]      reg_addr = '0;
  logic [15:0]     reg_wdata = '0;
  logic            reg_write = 0;
  logic            reg_read = 0;
  logic [15:0]     reg_rdata;
  logic [1:0]      corr_start;
  logic [1:0]      use_val;
  logic [1:0][7:0] corr_value;
  logic [1:0][7:0] corr_result = '0;
  logic [1:0]      corr_done = '0;
  logic            short_rm;
  logic            outp_on;
  logic            dly_on;
  logic            rd_d = 0;
  logic [15:0]     wv;
  logic [15:0]     v;
  int              dly[2] = '{0, 0};
  int              n_start[2] = '{0, 0};
  int              fail_count = 0;
  int              n_checks = 0;
  int              cycles = 0;
  int              slow = 0;
  int              n0;
  note_t           notes[$];

  headphone_dc_servo_registers #(.unit_cycles(4)) dut_u (
    .clk                        (clk),
    .resetn                     (resetn),
    .reg_addr                   (reg_addr),
    .reg_wdata                  (reg_wdata),
    .reg_write                  (reg_write),
    .reg_read                   (reg_read),
    .reg_rdata                  (reg_rdata),
    .corr_start                 (corr_start),
    .corr_use_value             (use_val),
    .corr_value                 (corr_value),
    .corr_done                  (corr_done),
    .corr_result                (corr_result),
    .left_short_removal         (short_rm),
    .left_output_stage_on       (outp_on),
    .left_intermediate_stage_on (dly_on)
  );

  initial forever #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  task chk(string what, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task wr(logic [7:0] a, logic [15:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1;
    @(posedge clk);
    #1;
    reg_write = 0;
  endtask

  task rd(logic [7:0] a, logic [15:0] e);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_read = 1;
    notes.push_back('{a, e});
    @(posedge clk);
    #1;
    reg_read = 0;
  endtask

  task wait_idle;
    int q;
    q = 0;
    repeat (400) begin
      @(posedge clk);
      #2;
      if (dly[0] == 0 && dly[1] == 0 && corr_start == 2'b00)
        q++;
      else
        q = 0;
      if (q == 3)
        break;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // read results, oldest note first; plus the run limit
  always @(posedge clk) begin
    if (rd_d) begin
      chk($sformatf("reg %h", notes[0].a), reg_rdata, notes[0].e);
      void'(notes.pop_front());
    end
    rd_d <= reg_read;
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      fail_count++;
      conclude();
    end
  end

  // stands in for the analogue servo: one done pulse per start
  always @(posedge clk) begin
    #1;
    for (int i = 0; i < 2; i++) begin
      corr_done[i] = 0;
      if (dly[i] == 1) begin
        corr_done[i] = 1;
        corr_result[i] = 8'($urandom);
      end
      if (dly[i] != 0)
        dly[i]--;
      if (corr_start[i]) begin
        dly[i] = (slow != 0) ? 30 : 1 + $urandom % 4;
        n_start[i]++;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(42078));
    repeat (4) @(posedge clk);
    #1;
    resetn = 1;
    rd(ADDR_SERIES_TIMER, 16'h054a);
    rd(ADDR_WRITE_VALUES, 16'h0000);
    rd(ADDR_COMPLETION, 16'h0000);
    rd(ADDR_LEFT_RB, 16'h0000);
    rd(ADDR_HP_STAGE, 16'h0000);
    v = 16'($urandom) & 16'h0fe0;
    wr(ADDR_SERIES_TIMER, v);
    rd(ADDR_SERIES_TIMER, v);
    wv = 16'($urandom);
    wr(ADDR_WRITE_VALUES, wv);
    rd(ADDR_WRITE_VALUES, wv);
    chk("corr value", corr_value, wv);
    wr(ADDR_COMPLETION, 16'hffff);
    rd(ADDR_COMPLETION, 16'h0000);
    rd(8'h70, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_HP_STAGE, 16'(k) << 5);
      chk("stage pins", {13'h0, short_rm, outp_on, dly_on}, 16'(k));
      rd(ADDR_HP_STAGE, 16'(k) << 5);
    end
    wr(ADDR_HP_STAGE, 16'h0000);
    repeat (1000) @(posedge clk);
    wr(ADDR_HP_STAGE, 16'h0020);
    n0 = n_start[0] + n_start[1];
    wr(ADDR_SERVO_CTRL, 16'h033c);
    repeat (10) @(posedge clk);
    chk("starts while off", 16'(n_start[0] + n_start[1] - n0), 16'h0);
    wr(ADDR_SERVO_CTRL, 16'h000f);
    wait_idle();
    rd(ADDR_COMPLETION, 16'h0330);
    rd(ADDR_LEFT_RB, {8'h00, wv[15:8]});
    rd(ADDR_RIGHT_RB, {8'h00, wv[7:0]});
    wr(ADDR_SERVO_CTRL, 16'h0033);
    wait_idle();
    rd(ADDR_COMPLETION, 16'h0333);
    rd(ADDR_LEFT_RB, {8'h00, corr_result[1]});
    rd(ADDR_RIGHT_RB, {8'h00, corr_result[0]});
    wr(ADDR_HP_STAGE, 16'h0060);
    wr(ADDR_HP_STAGE, 16'h00e0);
    chk("stage pins", {13'h0, short_rm, outp_on, dly_on}, 16'h0007);
    slow = 1;
    wr(ADDR_SERVO_CTRL, 16'h000b);
    rd(ADDR_COMPLETION, 16'h0313);
    rd(ADDR_SERVO_CTRL, 16'h000b);
    chk("use value", {14'h0, use_val}, 16'h0002);
    wait_idle();
    rd(ADDR_COMPLETION, 16'h0333);
    rd(ADDR_LEFT_RB, {8'h00, wv[15:8]});
    wr(ADDR_SERIES_TIMER, 16'h0060);
    n0 = n_start[1];
    wr(ADDR_SERVO_CTRL, 16'h0202);
    rd(ADDR_SERVO_CTRL, 16'h0202);
    chk("use value", {14'h0, use_val}, 16'h0000);
    slow = 0;
    wait_idle();
    chk("series starts", 16'(n_start[1] - n0), 16'h0004);
    wr(ADDR_SERIES_TIMER, 16'h0001);
    n0 = n_start[1];
    repeat (40) @(posedge clk);
    chk("periodic", 16'(n_start[1] - n0), 16'h0004);
    wr(ADDR_SERIES_TIMER, 16'h0000);
    wait_idle();
    n0 = n_start[1];
    repeat (40) @(posedge clk);
    chk("timer off", 16'(n_start[1] - n0), 16'h0000);
    chk("notes left", 16'(notes.size()), 16'h0000);
    conclude();
  end
endmodule // headphone_dc_servo_registers_tb_top
